// File: pack_cfg_regs.vh
`ifndef PACK_CFG_REGS_VH
`define PACK_CFG_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CHG_CFG_ADDR       8'h06
`define FEAT_CFG_ADDR      8'h07
`define WREN_ADDR          8'h08
`define CFG_RESET          8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define CHG_OC_AUTO_OFF_DIS_BIT  7
`define CHG_OC_THR_HI_BIT        6
`define CHG_OC_THR_LO_BIT        5
`define SC_LONG_DELAY_BIT        4
`define CHG_DIV32_BIT            3
`define DIS_DIV64_BIT            2
`define CHG_OC_TO_HI_BIT         1
`define CHG_OC_TO_LO_BIT         0
`define TEMP_SCAN_DIS_BIT        7
`define REG_DIS_BIT              6
`define SUPPLY_FORCE_BIT         5
`define EXT_TSD_DIS_BIT          4
`define INT_TSD_DIS_BIT          3
`define FORCE_POR_BIT            2
`define WAKE_DIS_BIT             1
`define WAKE_POL_BIT             0
`define FEAT_WREN_BIT            7
`define CHG_WREN_BIT             6
// ----------------------------------------
// timing, 100 mhz clock, 1 us tick
// ----------------------------------------
`define CLK_MHZ            100
`define TICK_DIV           (`CLK_MHZ)
`define SC_SHORT_US        190
`define SC_LONG_US         10000
`define CHG_OC_BASE_US     80000
`define CHG_OC_DIV         32
`define DIS_OC_DIV         64
`define SCAN_ON_US         5000
`define SCAN_PERIOD_US     640000
`endif

// File: tick_divider.v
`timescale 1ns/1ps
module tick_divider (
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire       clear_in,
  output reg        tick_out
);
`include "pack_cfg_regs.vh"
  reg [6:0] cnt_q;
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q    <= 7'h00;
      tick_out <= 1'b0;
    end else if (clear_in) begin
      cnt_q    <= 7'h00;
      tick_out <= 1'b0;
    end else if (cnt_q == 7'd99) begin
      cnt_q    <= 7'h00;
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 7'h01;
      tick_out <= 1'b0;
    end
  end
endmodule // tick_divider

// File: persist_timer.v
`timescale 1ns/1ps
module persist_timer (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire        clear_in,
  input  wire        tick_in,
  input  wire        cond_in,
  input  wire [19:0] limit_in,
  output reg         expired_out
);
  reg [19:0] cnt_q;
  // any gap in the condition restarts the count
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q       <= 20'h00000;
      expired_out <= 1'b0;
    end else if (clear_in || !cond_in) begin
      cnt_q       <= 20'h00000;
      expired_out <= 1'b0;
    end else if (tick_in && !expired_out) begin
      if (cnt_q + 20'h00001 >= limit_in) begin
        expired_out <= 1'b1;
      end
      cnt_q <= cnt_q + 20'h00001;
    end
  end
endmodule // persist_timer

// File: pack_protection_config_regs.v
`timescale 1ns/1ps
module pack_protection_config_regs (
  input  wire        clk_in,
  input  wire        resetn_in,
  input  wire        wr_en_in,
  input  wire [7:0]  wr_addr_in,
  input  wire [7:0]  wr_data_in,
  input  wire [7:0]  rd_addr_in,
  input  wire        chg_oc_detect_in,
  input  wire        sc_detect_in,
  input  wire        ext_overtemp_in,
  input  wire        int_overtemp_in,
  input  wire        wake_pin_in,
  input  wire        asleep_in,
  input  wire        flag_clear_in,
  input  wire        charge_switch_set_in,
  output reg  [7:0]  rd_data_out,
  output reg  [1:0]  chg_oc_threshold_out,
  output reg         chg_oc_expired_out,
  output reg         sc_expired_out,
  output reg         dischg_div64_out,
  output reg         power_fet_off_out,
  output reg         balance_off_out,
  output reg         charge_switch_on_out,
  output reg         chg_overcurrent_flag_out,
  output reg         ext_overtemp_flag_out,
  output reg         int_overtemp_flag_out,
  output reg         temp_sensor_supply_out,
  output reg         regulator_enable_out,
  output reg         wake_event_out,
  output reg         por_out
);
`include "pack_cfg_regs.vh"
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0]  chg_cfg_q;
  reg  [7:0]  feat_cfg_q;
  reg  [7:0]  wren_q;
  reg         por_q;
  reg         wake_prev_q;
  reg  [19:0] scan_cnt_q;
  reg         scan_on_q;
  wire        tick;
  wire        oc_exp;
  wire        sc_exp;
  wire [19:0] oc_limit;
  wire [19:0] sc_limit;
  wire        chg_oc_auto_off_disable;
  wire        chg_delay_div32;
  wire        auto_temp_scan_disable;
  wire        regulator_disable;
  wire        sensor_supply_force_on;
  wire        ext_thermal_shutdown_disable;
  wire        int_thermal_shutdown_disable;
  wire        wake_pin_disable;
  wire        wake_edge_polarity;
  wire        oc_trip;
  wire        xot_trip;
  wire        iot_trip;
  wire        wake_edge;
  wire        chg_flag_d;
  wire        any_trip;
  wire        wr_chg_hit;
  wire        wr_feat_hit;
  wire        wr_wren_hit;

  // ----------------------------------------
  // timing constants, in 1 us ticks
  // ----------------------------------------
  // 20 bits hold the whole 640 ms scan period, so no wider counters
  localparam [19:0] SC_SHORT_TICKS = 20'd`SC_SHORT_US;
  localparam [19:0] SC_LONG_TICKS  = 20'd`SC_LONG_US;
  localparam [19:0] OC_BASE_TICKS  = 20'd`CHG_OC_BASE_US;
  localparam [19:0] OC_DIV32       = 20'd`CHG_OC_DIV;
  localparam [19:0] SCAN_ON_TICKS  = 20'd`SCAN_ON_US;
  localparam [19:0] SCAN_LAST_TICK = 20'd`SCAN_PERIOD_US - 20'd1;

  assign chg_oc_auto_off_disable      = chg_cfg_q[`CHG_OC_AUTO_OFF_DIS_BIT];
  assign chg_delay_div32              = chg_cfg_q[`CHG_DIV32_BIT];
  assign auto_temp_scan_disable       = feat_cfg_q[`TEMP_SCAN_DIS_BIT];
  assign regulator_disable            = feat_cfg_q[`REG_DIS_BIT];
  assign sensor_supply_force_on       = feat_cfg_q[`SUPPLY_FORCE_BIT];
  assign ext_thermal_shutdown_disable = feat_cfg_q[`EXT_TSD_DIS_BIT];
  assign int_thermal_shutdown_disable = feat_cfg_q[`INT_TSD_DIS_BIT];
  assign wake_pin_disable             = feat_cfg_q[`WAKE_DIS_BIT];
  assign wake_edge_polarity           = feat_cfg_q[`WAKE_POL_BIT];

  // ----------------------------------------
  // delay selection
  // ----------------------------------------
  function [19:0] oc_delay_us;
    input [1:0] code;
    input       div32;
    reg   [19:0] base;
    begin
      base = OC_BASE_TICKS << code;
      if (div32) begin
        oc_delay_us = base / OC_DIV32;
      end else begin
        oc_delay_us = base;
      end
    end
  endfunction

  // sticky flag: a new event in the clear cycle keeps the flag set
  function sticky;
    input set;
    input held;
    input clear;
    begin
      sticky = set || (held && !clear);
    end
  endfunction

  assign oc_limit = oc_delay_us(chg_cfg_q[`CHG_OC_TO_HI_BIT:`CHG_OC_TO_LO_BIT],
                                chg_delay_div32);
  assign sc_limit = chg_cfg_q[`SC_LONG_DELAY_BIT] ? SC_LONG_TICKS : SC_SHORT_TICKS;

  // forced reset is one cycle of clear, so it is synchronous
  tick_divider u_tick (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (por_q),
    .tick_out  (tick)
  );

  persist_timer u_oc_timer (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .clear_in    (por_q),
    .tick_in     (tick),
    .cond_in     (chg_oc_detect_in),
    .limit_in    (oc_limit),
    .expired_out (oc_exp)
  );

  persist_timer u_sc_timer (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .clear_in    (por_q),
    .tick_in     (tick),
    .cond_in     (sc_detect_in),
    .limit_in    (sc_limit),
    .expired_out (sc_exp)
  );

  assign oc_trip    = oc_exp && !chg_oc_auto_off_disable;
  assign xot_trip   = ext_overtemp_in && !ext_thermal_shutdown_disable;
  assign iot_trip   = int_overtemp_in && !int_thermal_shutdown_disable;
  assign wake_edge  = wake_edge_polarity ? (wake_pin_in && !wake_prev_q) :
                                           (!wake_pin_in && wake_prev_q);
  assign chg_flag_d = sticky(oc_exp, chg_overcurrent_flag_out, flag_clear_in);
  // short circuit has no disable bit in this block, so it always trips
  assign any_trip   = oc_trip || xot_trip || iot_trip || sc_exp;
  // enable is the stored 08h value, so a write to 08h never opens its own cycle
  assign wr_chg_hit  = wr_en_in && (wr_addr_in == `CHG_CFG_ADDR) && wren_q[`CHG_WREN_BIT];
  assign wr_feat_hit = wr_en_in && (wr_addr_in == `FEAT_CFG_ADDR) && wren_q[`FEAT_WREN_BIT];
  assign wr_wren_hit = wr_en_in && (wr_addr_in == `WREN_ADDR);

  // ----------------------------------------
  // register writes and forced reset
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chg_cfg_q  <= `CFG_RESET;
      feat_cfg_q <= `CFG_RESET;
      wren_q     <= `CFG_RESET;
      por_q      <= 1'b0;
    end else if (por_q) begin
      chg_cfg_q  <= `CFG_RESET;
      feat_cfg_q <= `CFG_RESET;
      wren_q     <= `CFG_RESET;
      por_q      <= 1'b0;
    end else begin
      if (wr_wren_hit) begin
        wren_q <= wr_data_in;
      end
      if (wr_chg_hit) begin
        chg_cfg_q <= wr_data_in;
      end
      if (wr_feat_hit) begin
        // reset bit is a strobe, never stored
        feat_cfg_q <= wr_data_in & 8'hfb;
        por_q      <= wr_data_in[`FORCE_POR_BIT];
      end
    end
  end

  // ----------------------------------------
  // temperature scan, 5 ms of every 640 ms
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scan_cnt_q <= 20'h00000;
      scan_on_q  <= 1'b0;
    end else if (por_q || auto_temp_scan_disable) begin
      scan_cnt_q <= 20'h00000;
      scan_on_q  <= 1'b0;
    end else if (tick) begin
      if (scan_cnt_q == SCAN_LAST_TICK) begin
        scan_cnt_q <= 20'h00000;
      end else begin
        scan_cnt_q <= scan_cnt_q + 20'h00001;
      end
      scan_on_q <= (scan_cnt_q < SCAN_ON_TICKS - 20'd1) || (scan_cnt_q == SCAN_LAST_TICK);
    end
  end

  // ----------------------------------------
  // outputs and flags
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out              <= 8'h00;
      chg_oc_threshold_out     <= 2'h0;
      chg_oc_expired_out       <= 1'b0;
      sc_expired_out           <= 1'b0;
      dischg_div64_out         <= 1'b0;
      power_fet_off_out        <= 1'b0;
      balance_off_out          <= 1'b0;
      charge_switch_on_out     <= 1'b0;
      chg_overcurrent_flag_out <= 1'b0;
      ext_overtemp_flag_out    <= 1'b0;
      int_overtemp_flag_out    <= 1'b0;
      temp_sensor_supply_out   <= 1'b0;
      regulator_enable_out     <= 1'b1;
      por_out                  <= 1'b0;
    end else begin
      case (rd_addr_in)
        `CHG_CFG_ADDR:  rd_data_out <= chg_cfg_q;
        `FEAT_CFG_ADDR: rd_data_out <= feat_cfg_q;
        `WREN_ADDR:     rd_data_out <= wren_q;
        default:        rd_data_out <= 8'h00;
      endcase
      chg_oc_threshold_out <= chg_cfg_q[`CHG_OC_THR_HI_BIT:`CHG_OC_THR_LO_BIT];
      chg_oc_expired_out   <= oc_exp;
      sc_expired_out       <= sc_exp;
      dischg_div64_out     <= chg_cfg_q[`DIS_DIV64_BIT];
      power_fet_off_out    <= any_trip;
      balance_off_out      <= xot_trip || iot_trip;
      if (por_q) begin
        charge_switch_on_out     <= 1'b0;
        chg_overcurrent_flag_out <= 1'b0;
        ext_overtemp_flag_out    <= 1'b0;
        int_overtemp_flag_out    <= 1'b0;
      end else begin
        if (oc_trip || xot_trip || iot_trip) begin
          charge_switch_on_out <= 1'b0;
        end else if (charge_switch_set_in) begin
          charge_switch_on_out <= 1'b1;
        end
        chg_overcurrent_flag_out <= chg_flag_d;
        ext_overtemp_flag_out    <= sticky(ext_overtemp_in, ext_overtemp_flag_out,
                                           flag_clear_in);
        int_overtemp_flag_out    <= sticky(int_overtemp_in, int_overtemp_flag_out,
                                           flag_clear_in);
      end
      // supply follows flag, force bit or scan window
      temp_sensor_supply_out <= chg_flag_d || sensor_supply_force_on || scan_on_q;
      regulator_enable_out   <= !regulator_disable;
      por_out                <= por_q;
    end
  end

  // ----------------------------------------
  // wake edge detect
  // ----------------------------------------
  // reset low: a high idle pin reads as a rise, ignored by the default falling edge
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_prev_q    <= 1'b0;
      wake_event_out <= 1'b0;
    end else begin
      wake_prev_q    <= wake_pin_in;
      wake_event_out <= asleep_in && !wake_pin_disable && wake_edge;
    end
  end
endmodule // pack_protection_config_regs

// File: pack_cfg_asserts.sv
`timescale 1ns/1ps
module pack_cfg_asserts (
  input logic       clk_in, resetn_in, sc_detect_in, chg_oc_detect_in,
  input logic       ext_overtemp_in, int_overtemp_in, sc_expired_out,
  input logic       chg_oc_expired_out, ext_overtemp_flag_out, int_overtemp_flag_out,
  input logic       charge_switch_on_out, wake_event_out, por_out,
  input logic [7:0] rd_addr_in, rd_data_out
);
  // ----------------------------------------
  // short circuit run length, in cycles
  // ----------------------------------------
  int sc_run;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) sc_run <= 0;
    else sc_run <= sc_detect_in ? sc_run + 1 : 0;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // tick phase may eat up to one period of the 190 ticks
  sc_min_a: assert property ($rose(sc_expired_out) |-> sc_run >= 18900)
    else $error("short circuit expired early");
  sc_drop_a: assert property (!sc_detect_in |-> ##2 !sc_expired_out)
    else $error("short circuit timer kept running");
  oc_drop_a: assert property (!chg_oc_detect_in |-> ##2 !chg_oc_expired_out)
    else $error("overcurrent timer kept running");
  por_pulse_a: assert property (por_out |=> !por_out)
    else $error("forced reset strobe too long");
  por_clear_a: assert property (por_out |-> !ext_overtemp_flag_out && !int_overtemp_flag_out
    && !charge_switch_on_out)
    else $error("forced reset left state set");
  wake_pulse_a: assert property (wake_event_out |=> !wake_event_out)
    else $error("wake pulse too long");
  rd_unmapped_a: assert property (!(rd_addr_in inside {8'h06, 8'h07, 8'h08})
    |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  ext_flag_a: assert property (ext_overtemp_in |-> ##[1:3] ext_overtemp_flag_out)
    else $error("external overtemp flag missing");
  int_flag_a: assert property (int_overtemp_in |-> ##[1:3] int_overtemp_flag_out)
    else $error("internal overtemp flag missing");
  cover property ($rose(sc_expired_out));
  cover property (por_out);
  cover property (wake_event_out);
endmodule // pack_cfg_asserts

// File: host_model.sv
`timescale 1ns/1ps
module host_model (
  input  logic       clk_in,
  input  logic [7:0] rd_data_out,
  output logic       wr_en_in,
  output logic [7:0] wr_addr_in, wr_data_in, rd_addr_in
);
  initial begin
    wr_en_in = 1'b0;
    {wr_addr_in, wr_data_in, rd_addr_in} = 24'h000000;
  end
  // released data lines show the inverse, not the stale byte
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_in);
    wr_en_in   <= 1'b1;
    wr_addr_in <= a;
    wr_data_in <= x;
    @(posedge clk_in);
    wr_en_in   <= 1'b0;
    wr_data_in <= ~x;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk_in);
    rd_addr_in <= a;
    @(posedge clk_in);
    rd_addr_in <= 8'h00;
    @(negedge clk_in);
    x = rd_data_out;
  endtask
endmodule // host_model

// File: pack_protection_config_regs_bench.sv
`timescale 1ns/1ps
module pack_protection_config_regs_bench;
  logic       clk_in, resetn_in, wr_en_in, chg_oc_detect_in, sc_detect_in;
  logic       ext_overtemp_in, int_overtemp_in, wake_pin_in, asleep_in;
  logic       flag_clear_in, charge_switch_set_in, chg_oc_expired_out, sc_expired_out;
  logic       dischg_div64_out, power_fet_off_out, balance_off_out, charge_switch_on_out;
  logic       chg_overcurrent_flag_out, ext_overtemp_flag_out, int_overtemp_flag_out;
  logic       temp_sensor_supply_out, regulator_enable_out, wake_event_out, por_out;
  logic [7:0] wr_addr_in, wr_data_in, rd_addr_in, rd_data_out, v, d;
  logic [1:0] chg_oc_threshold_out;
  int         failures, n_checks, seed, i, n, wakes, pors;
  int         mdl [256];
  pack_protection_config_regs dut (.clk_in, .resetn_in, .wr_en_in, .wr_addr_in, .wr_data_in,
    .rd_addr_in, .chg_oc_detect_in, .sc_detect_in, .ext_overtemp_in, .int_overtemp_in,
    .wake_pin_in, .asleep_in, .flag_clear_in, .charge_switch_set_in, .rd_data_out,
    .chg_oc_threshold_out, .chg_oc_expired_out, .sc_expired_out, .dischg_div64_out,
    .power_fet_off_out, .balance_off_out, .charge_switch_on_out, .chg_overcurrent_flag_out,
    .ext_overtemp_flag_out, .int_overtemp_flag_out, .temp_sensor_supply_out,
    .regulator_enable_out, .wake_event_out, .por_out);
  host_model host (.clk_in, .rd_data_out, .wr_en_in, .wr_addr_in, .wr_data_in, .rd_addr_in);
  // ----------------------------------------
  // checking and register model
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    host.wr(a, x);
    if (a == 8'h08 || (a == 8'h06 && mdl[8][6]) || (a == 8'h07 && mdl[8][7]))
      mdl[a] = (a == 8'h07) ? x & 8'hfb : x;
    if (a == 8'h07 && mdl[8][7] && x[2]) mdl = '{default: 0};
  endtask
  task automatic rchk(input logic [7:0] a);
    host.rd(a, d);
    chk(d, 8'(mdl[a]));
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  always @(posedge clk_in) if (wake_event_out) wakes++;
  always @(posedge clk_in) if (por_out) pors++;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    stop_test;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn_in = 1'b0;
    {chg_oc_detect_in, sc_detect_in, ext_overtemp_in, int_overtemp_in} = 4'h0;
    {wake_pin_in, asleep_in, flag_clear_in, charge_switch_set_in} = 4'h0;
    seed = 97;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    chk(8'(regulator_enable_out), 8'h01);
    wr(8'h06, 8'hff);
    wr(8'h07, 8'hfb);
    for (i = 5; i < 10; i++) rchk(i[7:0]);
    $display("reset and refusal done");
    cyc(200);
    chk(8'(temp_sensor_supply_out), 8'h01);
    wr(8'h08, 8'hc0);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      v[6:5] = i[1:0];
      wr(8'h06, v);
      rchk(8'h06);
      chk(8'(chg_oc_threshold_out), 8'(v[6:5]));
      chk(8'(dischg_div64_out), 8'(v[2]));
    end
    $display("threshold codes done");
    wr(8'h07, 8'hd0);
    rchk(8'h07);
    chk(8'(regulator_enable_out), 8'h00);
    chk(8'(temp_sensor_supply_out), 8'h00);
    wr(8'h07, 8'hb0);
    cyc(2);
    chk(8'(temp_sensor_supply_out), 8'h01);
    @(posedge clk_in) ext_overtemp_in <= 1'b1;
    cyc(4);
    chk({ext_overtemp_flag_out, balance_off_out, power_fet_off_out}, 8'h04);
    @(posedge clk_in) ext_overtemp_in <= 1'b0;
    int_overtemp_in <= 1'b1;
    cyc(4);
    chk({int_overtemp_flag_out, balance_off_out}, 8'h03);
    @(posedge clk_in) int_overtemp_in <= 1'b0;
    $display("thermal done");
    wr(8'h06, 8'h00);
    @(posedge clk_in) sc_detect_in <= 1'b1;
    cyc(5000);
    @(posedge clk_in) sc_detect_in <= 1'b0;
    @(posedge clk_in) sc_detect_in <= 1'b1;
    n = 0;
    while (sc_expired_out !== 1'b1 && n < 25000) begin
      @(negedge clk_in);
      n++;
    end
    chk(8'(n > 18900 && n < 19300), 8'h01);
    if (n == 25000) stop_test;
    cyc(3);
    chk(8'(power_fet_off_out), 8'h01);
    @(posedge clk_in) sc_detect_in <= 1'b0;
    $display("short circuit done");
    asleep_in <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wr(8'h07, (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'h02);
      wake_pin_in <= (i != 0);
      cyc(4);
      n = wakes;
      @(posedge clk_in) wake_pin_in <= (i == 0);
      cyc(8);
      chk(8'(wakes - n), (i == 2) ? 8'h00 : 8'h01);
    end
    $display("wake done");
    @(posedge clk_in) charge_switch_set_in <= 1'b1;
    @(posedge clk_in) charge_switch_set_in <= 1'b0;
    cyc(2);
    chk(8'(charge_switch_on_out), 8'h01);
    @(posedge clk_in) ext_overtemp_in <= 1'b1;
    @(posedge clk_in) ext_overtemp_in <= 1'b0;
    cyc(2);
    chk({charge_switch_on_out, ext_overtemp_flag_out}, 8'h01);
    @(posedge clk_in) flag_clear_in <= 1'b1;
    @(posedge clk_in) flag_clear_in <= 1'b0;
    cyc(2);
    chk({chg_overcurrent_flag_out, ext_overtemp_flag_out, int_overtemp_flag_out}, 8'h00);
    wr(8'h07, 8'h04);
    cyc(3);
    for (i = 6; i < 9; i++) rchk(i[7:0]);
    chk(8'(pors), 8'h01);
    wr(8'h06, 8'hff);
    rchk(8'h06);
    $display("forced reset done");
    stop_test;
  end
endmodule // pack_protection_config_regs_bench
bind pack_protection_config_regs pack_cfg_asserts chk_i (.clk_in, .resetn_in, .sc_detect_in,
  .chg_oc_detect_in, .ext_overtemp_in, .int_overtemp_in, .sc_expired_out, .chg_oc_expired_out,
  .ext_overtemp_flag_out, .int_overtemp_flag_out, .charge_switch_on_out, .wake_event_out,
  .por_out, .rd_addr_in, .rd_data_out);
